/* File: logic/tsm_consts.vh */
// Offsets, field positions, reset values and timing counts of the thermal sensor monitor
`ifndef TSM_CONSTS_VH
`define TSM_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TSM_OFS_INT_MASK_STATUS 12'h538
`define TSM_OFS_THRESHOLD_STATUS 12'h53c
`define TSM_OFS_TEST_CONTROL 12'h5d4
`define TSM_OFS_SENSOR0_RUN 12'h5d8
`define TSM_OFS_SENSOR1_RUN 12'h5dc
`define TSM_OFS_SENSOR2_RUN 12'h5e0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TSM_INT_STATUS_LSB 0
`define TSM_INT_MASK_LSB 16
`define TSM_OVER_LSB 0
`define TSM_THRESH_LSB 24
`define TSM_AUTO_TEST_BIT 31
`define TSM_RUN_BURST_BIT 0
`define TSM_RUN_SINGLE_BIT 1
`define TSM_RUN_PDOWN_BIT 2
`define TSM_RUN_RESULT_LSB 8
`define TSM_RUN_DONE_BIT 23
`define TSM_TEST_ITEM_LSB 0
`define TSM_TEST_CS_LSB 4
`define TSM_TEST_EN_BIT 6
`define TSM_TEST_PASS_BIT 8
`define TSM_TEST_M8_BIT 9
`define TSM_TEST_M9_BIT 10
`define TSM_TEST_DONE_BIT 15

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define TSM_INT_MASK_RESET 3'h7
`define TSM_LIMIT_CODE0 12'h06e
`define TSM_LIMIT_CODE1 12'h078
`define TSM_LIMIT_CODE2 12'h082
`define TSM_LIMIT_CODE3 12'h08c

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TSM_BURST_GAP_CYCLES 1024

`endif

/* File: logic/tsm_thermal_monitor.v */
// Register front end for three on-chip temperature sensors
//
// Contract
// - Three read-only over-threshold status bits, one per sensor, lowest bits, reset zero.
// - Per-sensor 2-bit threshold field; codes select 110, 120, 130, 140 degrees.
// - Top bit of threshold register enables automatic burst test; resets zero.
// - Burst-run bit repeatedly starts conversions; clearing it stops them while the automatic burst test bit is clear.
// - Single-run bit performs exactly one conversion and stores its result.
// - Power-down bit turns the sensor off when 1; resets zero.
// - Latest 12-bit result readable at bits 19:8, resets zero.
// - Done bit 23 reads 1 once a conversion completed.
// - Writable 4-bit test item select, resets zero.
// - 2-bit chip select picks sensor under test; code 11b reserved.
// - Bit 6 enables the sensor digital test.
// - Bit 8 reports overall digital test pass or fail.
// - Bits 9 and 10 report pass or fail of test modes 8 and 9.
// - Bit 15 reads 1 once the digital test completed.
// - Mask-and-status register: write-one-to-clear status, mask bits reset all ones.
// - Run register layout repeats for sensors 1 and 2.
`timescale 1ns/1ps
`include "tsm_consts.vh"

module tsm_thermal_monitor #(
    parameter BURST_GAP = `TSM_BURST_GAP_CYCLES
) (
    input wire clk,
    input wire sys_rst,
    input wire clk_en,
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [11:0] cfg_addr,
    input wire [31:0] cfg_wdata,
    output reg [31:0] cfg_rdata,
    output reg cfg_rvalid,
    output reg [2:0] sens_start,
    output reg [2:0] sens_power_down,
    input wire [2:0] sens_done,
    input wire [35:0] sens_data,
    output reg [3:0] test_item,
    output reg [1:0] test_chip_sel,
    output reg test_enable,
    input wire test_pass,
    input wire test_mode8_pass,
    input wire test_mode9_pass,
    input wire test_done
);

    localparam ST_IDLE = 1'b0;
    localparam ST_BUSY = 1'b1;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    reg [2:0] done_meta;
    reg [2:0] done_sync;
    reg [2:0] done_prev;
    reg [35:0] data_meta;
    reg [35:0] data_sync;
    reg [3:0] test_meta;
    reg [3:0] test_sync;

    always @(posedge clk) begin
        if (sys_rst) begin
            done_meta <= 3'h0;
            done_sync <= 3'h0;
            done_prev <= 3'h0;
            data_meta <= 36'h0;
            data_sync <= 36'h0;
            test_meta <= 4'h0;
            test_sync <= 4'h0;
        end else if (clk_en) begin
            done_meta <= sens_done;
            done_sync <= done_meta;
            done_prev <= done_sync;
            data_meta <= sens_data;
            data_sync <= data_meta;
            test_meta <= {test_done, test_mode9_pass, test_mode8_pass, test_pass};
            test_sync <= test_meta;
        end
    end

    // ----------------------------------------------------------------
    // Shared registers
    // ----------------------------------------------------------------
    reg [2:0] int_status;
    reg [2:0] int_mask;
    reg [5:0] thresh;
    reg auto_test;
    reg [2:0] over;
    reg test_pass_r;
    reg test_m8_r;
    reg test_m9_r;
    reg test_done_r;
    wire [2:0] over_event;
    wire [2:0] over_level;

    wire wr_int = cfg_wr && cfg_addr == `TSM_OFS_INT_MASK_STATUS;
    wire wr_thr = cfg_wr && cfg_addr == `TSM_OFS_THRESHOLD_STATUS;
    wire wr_tst = cfg_wr && cfg_addr == `TSM_OFS_TEST_CONTROL;

    always @(posedge clk) begin
        if (sys_rst) begin
            int_status <= 3'h0;
            int_mask <= `TSM_INT_MASK_RESET;
            thresh <= 6'h0;
            auto_test <= 1'b0;
            over <= 3'h0;
            test_item <= 4'h0;
            test_chip_sel <= 2'h0;
            test_enable <= 1'b0;
            test_pass_r <= 1'b0;
            test_m8_r <= 1'b0;
            test_m9_r <= 1'b0;
            test_done_r <= 1'b0;
        end else if (clk_en) begin
            // Hardware set wins over a simultaneous software clear
            if (wr_int) begin
                int_status <= (int_status & ~cfg_wdata[`TSM_INT_STATUS_LSB +: 3]) | over_event;
                int_mask <= cfg_wdata[`TSM_INT_MASK_LSB +: 3];
            end else begin
                int_status <= int_status | over_event;
            end
            if (wr_thr) begin
                thresh <= cfg_wdata[`TSM_THRESH_LSB +: 6];
                auto_test <= cfg_wdata[`TSM_AUTO_TEST_BIT];
            end
            over <= over_level;
            if (wr_tst) begin
                test_item <= cfg_wdata[`TSM_TEST_ITEM_LSB +: 4];
                test_chip_sel <= cfg_wdata[`TSM_TEST_CS_LSB +: 2];
                test_enable <= cfg_wdata[`TSM_TEST_EN_BIT];
            end
            // Results only mean something while the test is enabled
            test_pass_r <= test_enable & test_sync[0];
            test_m8_r <= test_enable & test_sync[1];
            test_m9_r <= test_enable & test_sync[2];
            test_done_r <= test_enable & test_sync[3];
        end
    end

    // ----------------------------------------------------------------
    // Per-sensor run control and conversion sequencing
    // ----------------------------------------------------------------
    wire [2:0] burst_bit;
    wire [2:0] single_bit;
    wire [35:0] result_bus;
    wire [2:0] conv_done_bit;

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : sensor
            reg burst;
            reg single;
            reg [11:0] result;
            reg conv_done;
            reg state;
            reg single_req;
            reg [31:0] gap_cnt;
            reg [11:0] limit;
            wire wr_run = cfg_wr && cfg_addr == `TSM_OFS_SENSOR0_RUN + 12'h004 * g;
            wire arm = wr_run && cfg_wdata[`TSM_RUN_SINGLE_BIT];
            wire finish = done_sync[g] & ~done_prev[g];
            wire [11:0] new_data = data_sync[12 * g +: 12];

            always @* begin
                case (thresh[2 * g +: 2])
                    2'h0: limit = `TSM_LIMIT_CODE0;
                    2'h1: limit = `TSM_LIMIT_CODE1;
                    2'h2: limit = `TSM_LIMIT_CODE2;
                    default: limit = `TSM_LIMIT_CODE3;
                endcase
            end

            always @(posedge clk) begin
                if (sys_rst) begin
                    burst <= 1'b0;
                    single <= 1'b0;
                    sens_power_down[g] <= 1'b0;
                    result <= 12'h0;
                    conv_done <= 1'b0;
                    state <= ST_IDLE;
                    single_req <= 1'b0;
                    gap_cnt <= 32'h0;
                    sens_start[g] <= 1'b0;
                end else if (clk_en) begin
                    sens_start[g] <= 1'b0;
                    if (wr_run) begin
                        burst <= cfg_wdata[`TSM_RUN_BURST_BIT];
                        single <= cfg_wdata[`TSM_RUN_SINGLE_BIT];
                        sens_power_down[g] <= cfg_wdata[`TSM_RUN_PDOWN_BIT];
                    end
                    // Each write of a one arms one conversion; power-down drops a pending one
                    single_req <= arm | (single_req & ~sens_power_down[g]);
                    if (gap_cnt != 32'h0) begin
                        gap_cnt <= gap_cnt - 32'h1;
                    end
                    case (state)
                        ST_IDLE: begin
                            if (!sens_power_down[g] && (single_req ||
                                ((burst || auto_test) && gap_cnt == 32'h0))) begin
                                sens_start[g] <= 1'b1;
                                single_req <= arm;
                                conv_done <= 1'b0;
                                state <= ST_BUSY;
                            end
                        end
                        ST_BUSY: begin
                            // Power-down abandons the conversion; the old result stays
                            if (sens_power_down[g]) begin
                                state <= ST_IDLE;
                            end else if (finish) begin
                                result <= new_data;
                                conv_done <= 1'b1;
                                gap_cnt <= BURST_GAP;
                                state <= ST_IDLE;
                            end
                        end
                        default: state <= ST_IDLE;
                    endcase
                end
            end

            assign over_event[g] = clk_en && state == ST_BUSY && !sens_power_down[g] &&
                                   finish && new_data > limit;
            assign over_level[g] = (state == ST_BUSY && !sens_power_down[g] && finish) ?
                                   (new_data > limit) : over[g];
            assign burst_bit[g] = burst;
            assign single_bit[g] = single;
            assign result_bus[12 * g +: 12] = result;
            assign conv_done_bit[g] = conv_done;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read path: one cycle latency, unmapped offsets read zero
    // ----------------------------------------------------------------
    reg [31:0] next_rdata;
    reg [1:0] run_idx;
    reg run_hit;

    always @* begin
        next_rdata = 32'h0;
        run_hit = 1'b0;
        run_idx = 2'h0;
        case (cfg_addr)
            `TSM_OFS_INT_MASK_STATUS: begin
                next_rdata[`TSM_INT_STATUS_LSB +: 3] = int_status;
                next_rdata[`TSM_INT_MASK_LSB +: 3] = int_mask;
            end
            `TSM_OFS_THRESHOLD_STATUS: begin
                next_rdata[`TSM_OVER_LSB +: 3] = over;
                next_rdata[`TSM_THRESH_LSB +: 6] = thresh;
                next_rdata[`TSM_AUTO_TEST_BIT] = auto_test;
            end
            `TSM_OFS_TEST_CONTROL: begin
                next_rdata[`TSM_TEST_ITEM_LSB +: 4] = test_item;
                next_rdata[`TSM_TEST_CS_LSB +: 2] = test_chip_sel;
                next_rdata[`TSM_TEST_EN_BIT] = test_enable;
                next_rdata[`TSM_TEST_PASS_BIT] = test_pass_r;
                next_rdata[`TSM_TEST_M8_BIT] = test_m8_r;
                next_rdata[`TSM_TEST_M9_BIT] = test_m9_r;
                next_rdata[`TSM_TEST_DONE_BIT] = test_done_r;
            end
            `TSM_OFS_SENSOR0_RUN: run_hit = 1'b1;
            `TSM_OFS_SENSOR1_RUN: begin
                run_hit = 1'b1;
                run_idx = 2'h1;
            end
            `TSM_OFS_SENSOR2_RUN: begin
                run_hit = 1'b1;
                run_idx = 2'h2;
            end
            default: next_rdata = 32'h0;
        endcase
        if (run_hit) begin
            next_rdata[`TSM_RUN_BURST_BIT] = burst_bit[run_idx];
            next_rdata[`TSM_RUN_SINGLE_BIT] = single_bit[run_idx];
            next_rdata[`TSM_RUN_PDOWN_BIT] = sens_power_down[run_idx];
            next_rdata[`TSM_RUN_RESULT_LSB +: 12] = result_bus[12 * run_idx +: 12];
            next_rdata[`TSM_RUN_DONE_BIT] = conv_done_bit[run_idx];
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            cfg_rdata <= 32'h0;
            cfg_rvalid <= 1'b0;
        end else if (clk_en) begin
            cfg_rvalid <= cfg_rd;
            if (cfg_rd) begin
                cfg_rdata <= next_rdata;
            end
        end
    end

endmodule

/* File: testbench/tsm_chk.sv */
// Assertion checker for the thermal sensor monitor ports
`timescale 1ns/1ps
`include "tsm_consts.vh"
module tsm_chk #(
    parameter BURST_GAP = 4
) (
    input wire clk,
    input wire sys_rst,
    input wire clk_en,
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [11:0] cfg_addr,
    input wire [31:0] cfg_wdata,
    input wire [31:0] cfg_rdata,
    input wire cfg_rvalid,
    input wire [2:0] sens_start,
    input wire [2:0] sens_power_down,
    input wire test_enable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    // A lone write is required so that a later write cannot mask a slow copy
    sequence s_run1_write;
        cfg_wr && clk_en && cfg_addr == `TSM_OFS_SENSOR1_RUN ##1 !cfg_wr;
    endsequence
    sequence s_test_write;
        cfg_wr && clk_en && cfg_addr == `TSM_OFS_TEST_CONTROL ##1 !cfg_wr;
    endsequence
    a_read_answered: assert property (cfg_rd && clk_en |=> cfg_rvalid)
        else $error("read was not answered one cycle later");
    // A frozen clock enable holds the valid flag, so only a running cycle needs a read behind it
    a_rvalid_cause: assert property (cfg_rvalid && $past(clk_en) |-> $past(cfg_rd))
        else $error("read valid without a read");
    a_rdata_hold: assert property (!cfg_rvalid |-> $stable(cfg_rdata))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (cfg_rd && clk_en && cfg_addr == 12'h000 |=> cfg_rdata == 32'h0)
        else $error("unmapped read returned data");
    a_burst_spacing: assert property (sens_start[2] |=> !sens_start[2] [*3])
        else $error("conversion starts too close together");
    a_pdown_blocks: assert property (sens_power_down[1] && $past(sens_power_down[1]) |-> !sens_start[1])
        else $error("start issued to a powered-down sensor");
    a_pdown_copy: assert property (s_run1_write |-> ##1 sens_power_down[1] == $past(cfg_wdata[2], 2))
        else $error("power-down output does not follow the written bit");
    a_test_enable: assert property (s_test_write |-> ##1 test_enable == $past(cfg_wdata[6], 2))
        else $error("test enable does not follow the written bit");
endmodule
bind tsm_thermal_monitor tsm_chk #(.BURST_GAP(BURST_GAP)) tsm_chk_inst (.clk(clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .sens_start(sens_start),
    .sens_power_down(sens_power_down), .test_enable(test_enable));

/* File: testbench/tb_top.sv */
// Self-checking testbench for the thermal sensor monitor
`timescale 1ns/1ps
`include "tsm_consts.vh"
module tb_top;
    localparam [11:0] thr = `TSM_OFS_THRESHOLD_STATUS;
    localparam [11:0] ints = `TSM_OFS_INT_MASK_STATUS;
    localparam [11:0] tst = `TSM_OFS_TEST_CONTROL;
    reg clk = 1'b0;
    reg sys_rst = 1'b1;
    reg clk_en = 1'b1;
    reg cfg_wr = 1'b0;
    reg cfg_rd = 1'b0;
    reg [11:0] cfg_addr = 12'h000;
    reg [31:0] cfg_wdata = 32'h0;
    reg [2:0] sens_done = 3'h0;
    reg [35:0] sens_data = 36'h0;
    reg [3:0] test_in = 4'h0;
    wire [31:0] cfg_rdata;
    wire cfg_rvalid;
    wire [2:0] sens_start;
    wire [2:0] sens_power_down;
    wire [3:0] test_item;
    wire [1:0] test_chip_sel;
    wire test_enable;
    integer err_total = 0;
    integer comparisons = 0;
    integer n;
    // Short burst gap keeps periodic conversions quick to observe
    tsm_thermal_monitor #(.BURST_GAP(4)) tsm_thermal_monitor_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .sens_start(sens_start), .sens_power_down(sens_power_down),
        .sens_done(sens_done), .sens_data(sens_data), .test_item(test_item), .test_chip_sel(test_chip_sel),
        .test_enable(test_enable), .test_pass(test_in[0]), .test_mode8_pass(test_in[1]),
        .test_mode9_pass(test_in[2]), .test_done(test_in[3]));
    initial begin
        forever #10 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // Bus and sensor tasks
    // ----------------------------------------------------------------
    task final_report;
        begin
            $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
            if (err_total == 0 && comparisons > 0) begin
                $display("Test passed");
            end else begin
                $display("Test failed");
            end
            $finish;
        end
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("BAD %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        begin
            @(posedge clk);
            cfg_wr <= 1'b1;
            cfg_addr <= a;
            cfg_wdata <= d;
            @(posedge clk);
            cfg_wr <= 1'b0;
            @(posedge clk);
        end
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        begin
            @(posedge clk);
            cfg_rd <= 1'b1;
            cfg_addr <= a;
            @(posedge clk);
            cfg_rd <= 1'b0;
            #1;
            chk("rvalid", {31'h0, cfg_rvalid}, 32'h1);
            chk($sformatf("reg %h", a), cfg_rdata, exp);
        end
    endtask
    task wait_start(input integer g);
        begin
            n = 0;
            // Look just after each edge so a one-cycle pulse is seen while it stands
            #1;
            while (sens_start[g] !== 1'b1 && n < 40) begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
            chk("sens_start", {31'h0, sens_start[g]}, 32'h1);
            if (sens_start[g] !== 1'b1) begin
                final_report;
            end
        end
    endtask
    task answer(input integer g);
        begin
            @(posedge clk);
            sens_done[g] <= 1'b1;
            repeat (6) @(posedge clk);
            sens_done[g] <= 1'b0;
        end
    endtask
    task quiet(input integer g, input integer cycles);
        begin
            n = 0;
            repeat (cycles) begin
                @(posedge clk);
                #1;
                n = n + (sens_start[g] !== 1'b0);
            end
            chk("stray starts", n, 0);
        end
    endtask
    task conv(input integer g, input logic [11:0] val);
        begin
            sens_data[12 * g +: 12] <= val;
            wr(12'(`TSM_OFS_SENSOR0_RUN + 4 * g), 32'h2);
            wait_start(g);
            answer(g);
            rd(12'(`TSM_OFS_SENSOR0_RUN + 4 * g), {8'h00, 4'h8, val, 8'h02});
        end
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_reset;
        begin
            rd(ints, 32'h0007_0000);
            rd(thr, 32'h0);
            rd(tst, 32'h0);
            rd(`TSM_OFS_SENSOR0_RUN, 32'h0);
            rd(`TSM_OFS_SENSOR2_RUN, 32'h0);
            rd(12'h000, 32'h0);
            chk("outputs", {23'h0, sens_start, sens_power_down, test_enable, test_chip_sel}, 32'h0);
            $display("reset test finished");
        end
    endtask
    task t_conv;
        begin
            wr(thr, 32'h2400_0007);
            rd(thr, 32'h2400_0000);
            conv(0, 12'h06f);
            conv(1, 12'h078);
            conv(2, 12'h083);
            rd(thr, 32'h2400_0005);
            rd(ints, 32'h0007_0005);
            wr(ints, 32'h0000_0005);
            rd(ints, 32'h0);
            wr(thr, 32'h2700_0000);
            conv(0, 12'h08c);
            rd(thr, 32'h2700_0004);
            conv(0, 12'h08d);
            rd(thr, 32'h2700_0005);
            $display("conversion test finished");
        end
    endtask
    task t_pdown;
        begin
            wr(`TSM_OFS_SENSOR1_RUN, 32'h6);
            #1;
            chk("power_down", {29'h0, sens_power_down}, 32'h2);
            quiet(1, 20);
            rd(`TSM_OFS_SENSOR1_RUN, {8'h00, 4'h8, 12'h078, 8'h06});
            wr(`TSM_OFS_SENSOR1_RUN, 32'h0);
            // A single run asked for while powered down must not fire on power-up
            quiet(1, 10);
            $display("power-down test finished");
        end
    endtask
    task t_burst;
        begin
            wr(`TSM_OFS_SENSOR2_RUN, 32'h1);
            wait_start(2);
            answer(2);
            wait_start(2);
            wr(`TSM_OFS_SENSOR2_RUN, 32'h0);
            answer(2);
            quiet(2, 40);
            // The automatic start follows the enabling write at once, so watch for it first
            wr(thr, 32'ha700_0000);
            wait_start(0);
            answer(0);
            rd(thr, 32'ha700_0005);
            wr(thr, 32'h2700_0000);
            $display("periodic test finished");
        end
    endtask
    task t_test;
        begin
            wr(tst, 32'h6a);
            #1;
            chk("test ports", {25'h0, test_enable, test_chip_sel, test_item}, 32'h6a);
            test_in <= 4'b1101;
            repeat (5) @(posedge clk);
            rd(tst, 32'h856a);
            test_in <= 4'b0010;
            repeat (5) @(posedge clk);
            rd(tst, 32'h026a);
            wr(tst, 32'h0000_ffff);
            repeat (3) @(posedge clk);
            rd(tst, 32'h027f);
            wr(tst, 32'h0);
            repeat (3) @(posedge clk);
            rd(tst, 32'h0);
            $display("self-test finished");
        end
    endtask
    task t_freeze;
        begin
            @(posedge clk);
            clk_en <= 1'b0;
            wr(tst, 32'h5);
            #1;
            chk("frozen item", {28'h0, test_item}, 32'h0);
            @(posedge clk);
            clk_en <= 1'b1;
            rd(tst, 32'h0);
            $display("clock-enable test finished");
        end
    endtask
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset;
        t_conv;
        t_pdown;
        t_burst;
        t_test;
        t_freeze;
        final_report;
    end
endmodule
